// ### rtl/led_fault_detect_removal.sv
// LED matrix protection, open/short diagnostics and open-LED blanking
//
// What this block does
// - Thermal trip disables all outputs until release point is reached.
// - Reference pin short disables all outputs until the pin recovers.
// - Open bit set when channel voltage exceeds open threshold, else zero.
// - Open comparator sampled only while its channel is driven.
// - Open threshold programmed per colour group; channel select is the low bit of its group code, so blue selects like red.
// - Open line recorded; open flags latched to 48-bit data per segment.
// - With open removal on, channel blanked on lines where it was open.
// - Blanking persists until reset or open removal enable cleared.
// - Only the first three lines with opens are tracked and blanked.
// - Short bit set when channel voltage below short threshold, else zero.
// - Short comparator sampled only while its channel is driven.
// - Short threshold set per colour group for weak short detection.
// - Short line recorded; short flags latched to 48-bit data per segment.
// - Short removal clamp selects level applied to unselected lines.
//
// Decided for this implementation: the APB interface to the registers and the register offsets.
`default_nettype none
module led_fault_detect_removal
   import led_fault_pkg::*;
#(
   parameter int N = CHANNELS,
   parameter int NL = LINES,
   parameter int SLOTS = REMOVAL_SLOTS
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic over_temp_trip,
   input wire logic over_temp_clear,
   input wire logic ref_short_trip,
   input wire logic ref_short_clear,
   input wire logic [N-1:0] open_cmp,
   input wire logic [N-1:0] short_cmp,
   input wire scan_t scan,
   output logic [N-1:0] channel_output,
   output analog_settings_t settings,
   output logic [N-1:0] open_channel_threshold_sel,
   output logic outputs_disabled
);
   // Pin synchronisers, two stages each
   logic [3:0] prot_meta;
   logic [3:0] prot_sync;
   logic [N-1:0] open_meta;
   logic [N-1:0] open_sync;
   logic [N-1:0] short_meta;
   logic [N-1:0] short_sync;

   // Protection state
   logic over_temp_shutdown;
   logic ref_resistor_short_guard;

   // Software registers
   logic [1:0] ctrl;
   logic [27:0] thresh;
   logic open_removal_enable;
   logic fault_readback_enable;

   // Fault capture results
   logic [N-1:0] open_seg;
   logic [N-1:0] short_seg;
   logic [N-1:0] open_data;
   logic [N-1:0] short_data;
   logic [NL-1:0] open_line_warning;
   logic [NL-1:0] short_line_warning;
   logic [NL-1:0] open_line_clear;
   logic [NL-1:0] short_line_clear;

   // Removal slots
   logic [SLOTS-1:0] slot_valid;
   logic [LINE_W-1:0] slot_line [SLOTS];
   logic [N-1:0] slot_mask [SLOTS];
   logic [N-1:0] blank;
   logic [1:0] removal_count;

   // Bus decode
   logic setup_phase;
   logic access_wr;
   logic addr_hit;
   logic [31:0] next_rdata;

   // Synchronise protection and comparator inputs
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         prot_meta <= 4'h0;
         prot_sync <= 4'h0;
         open_meta <= '0;
         open_sync <= '0;
         short_meta <= '0;
         short_sync <= '0;
      end
      else
      begin
         prot_meta <= {ref_short_clear, ref_short_trip,
                       over_temp_clear, over_temp_trip};
         prot_sync <= prot_meta;
         open_meta <= open_cmp;
         open_sync <= open_meta;
         short_meta <= short_cmp;
         short_sync <= short_meta;
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         over_temp_shutdown <= 1'b0;
      else if (prot_sync[0])
         over_temp_shutdown <= 1'b1;
      else if (prot_sync[1])
         over_temp_shutdown <= 1'b0;
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         ref_resistor_short_guard <= 1'b0;
      else if (prot_sync[2])
         ref_resistor_short_guard <= 1'b1;
      else if (prot_sync[3])
         ref_resistor_short_guard <= 1'b0;
   end

   assign outputs_disabled = over_temp_shutdown | ref_resistor_short_guard;

   // Control and threshold fields
   assign open_removal_enable = ctrl[OPEN_REMOVAL_BIT];
   assign fault_readback_enable = ctrl[READBACK_BIT];
   assign settings.open_threshold_red = thresh[OPEN_RED_POS +: THRESH_W];
   assign settings.open_threshold_green =
      thresh[OPEN_GREEN_POS +: THRESH_W];
   assign settings.open_threshold_blue = thresh[OPEN_BLUE_POS +: THRESH_W];
   assign settings.short_threshold_red = thresh[SHORT_RED_POS +: THRESH_W];
   assign settings.short_threshold_green =
      thresh[SHORT_GREEN_POS +: THRESH_W];
   assign settings.short_threshold_blue =
      thresh[SHORT_BLUE_POS +: THRESH_W];
   assign settings.short_removal_clamp = thresh[CLAMP_POS +: THRESH_W];

   // low bit of each channel's colour group code
   always_comb
   begin : group_sel
      logic [1:0] grp;
      grp = 2'h0;
      open_channel_threshold_sel = '0;
      for (int c = 0; c < N; c++)
      begin
         grp = color_group(c);
         open_channel_threshold_sel[c] = grp[0];
      end
   end

   // open faults, sampled while driven, record
   fault_capture #(
      .N(N),
      .NL(NL),
      .LW(LINE_W)
   ) u_open (
      .pclk(pclk),
      .presetn(presetn),
      .cmp(open_sync),
      .scan(scan),
      .line_clear(open_line_clear),
      .seg_flags(open_seg),
      .data(open_data),
      .line_warning(open_line_warning)
   );

   // short faults, sampled while driven, record
   fault_capture #(
      .N(N),
      .NL(NL),
      .LW(LINE_W)
   ) u_short (
      .pclk(pclk),
      .presetn(presetn),
      .cmp(short_sync),
      .scan(scan),
      .line_clear(short_line_clear),
      .seg_flags(short_seg),
      .data(short_data),
      .line_warning(short_line_warning)
   );

   // slot allocation for the first three open lines
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         slot_valid <= '0;
         for (int s = 0; s < SLOTS; s++)
         begin
            slot_line[s] <= '0;
            slot_mask[s] <= '0;
         end
      end
      else if (!open_removal_enable)
      begin
         slot_valid <= '0;
         for (int s = 0; s < SLOTS; s++)
            slot_mask[s] <= '0;
      end
      else if (scan.segment_end && |open_seg)
      begin : alloc
         logic found;
         logic placed;
         found = 1'b0;
         placed = 1'b0;
         for (int s = 0; s < SLOTS; s++)
         begin
            if (slot_valid[s] && slot_line[s] == scan.line)
            begin
               slot_mask[s] <= slot_mask[s] | open_seg;
               found = 1'b1;
            end
         end
         for (int s = 0; s < SLOTS; s++)
         begin
            if (!found && !placed && !slot_valid[s])
            begin
               slot_valid[s] <= 1'b1;
               slot_line[s] <= scan.line;
               slot_mask[s] <= open_seg;
               placed = 1'b1;
            end
         end
      end
   end

   // channels to blank on the line being scanned
   always_comb
   begin
      blank = '0;
      removal_count = 2'h0;
      for (int s = 0; s < SLOTS; s++)
      begin
         if (slot_valid[s])
         begin
            removal_count = removal_count + 2'h1;
            if (slot_line[s] == scan.line)
               blank = blank | slot_mask[s];
         end
      end
   end

   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         channel_output <= '0;
      else if (outputs_disabled)
         channel_output <= '0;
      else
         channel_output <= scan.channel_on & ~blank;
   end

   // APB phases; zero wait states
   assign setup_phase = psel & ~penable;
   assign access_wr = psel & penable & pwrite;
   assign pready = 1'b1;

   // Address decode of mapped words
   always_comb
   begin
      unique case (paddr)
         CTRL_OFFSET, THRESH_OFFSET, STATUS_OFFSET,
         OPEN_LINE_OFFSET, SHORT_LINE_OFFSET,
         OPEN_DATA_LO_OFFSET, OPEN_DATA_HI_OFFSET,
         SHORT_DATA_LO_OFFSET, SHORT_DATA_HI_OFFSET:
            addr_hit = 1'b1;
         default:
            addr_hit = 1'b0;
      endcase
   end

   assign pslverr = psel & penable & ~addr_hit;

   // Writable registers
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
      begin
         ctrl <= CTRL_RESET;
         thresh <= THRESH_RESET;
      end
      else if (access_wr && paddr == CTRL_OFFSET)
         ctrl <= pwdata[1:0];
      else if (access_wr && paddr == THRESH_OFFSET)
         thresh <= pwdata[27:0];
   end

   // Write one to clear line warnings
   assign open_line_clear = (access_wr && paddr == OPEN_LINE_OFFSET) ?
      pwdata[NL-1:0] : '0;
   assign short_line_clear = (access_wr && paddr == SHORT_LINE_OFFSET) ?
      pwdata[NL-1:0] : '0;

   // Read mux; fault data hidden unless readback enabled
   always_comb
   begin
      next_rdata = 32'h00000000;
      unique case (paddr)
         CTRL_OFFSET:
            next_rdata = {30'h0, ctrl};
         THRESH_OFFSET:
            next_rdata = {4'h0, thresh};
         STATUS_OFFSET:
         begin
            next_rdata[THERMAL_BIT] = over_temp_shutdown;
            next_rdata[REF_SHORT_BIT] = ref_resistor_short_guard;
            next_rdata[REMOVAL_COUNT_POS +: 2] = removal_count;
         end
         OPEN_LINE_OFFSET:
            next_rdata = 32'(open_line_warning);
         SHORT_LINE_OFFSET:
            next_rdata = 32'(short_line_warning);
         OPEN_DATA_LO_OFFSET:
            next_rdata = fault_readback_enable ? open_data[31:0] : 32'h0;
         OPEN_DATA_HI_OFFSET:
            next_rdata = fault_readback_enable ?
               32'(open_data[N-1:32]) : 32'h0;
         SHORT_DATA_LO_OFFSET:
            next_rdata = fault_readback_enable ? short_data[31:0] : 32'h0;
         SHORT_DATA_HI_OFFSET:
            next_rdata = fault_readback_enable ?
               32'(short_data[N-1:32]) : 32'h0;
         default:
            next_rdata = 32'h00000000;
      endcase
   end

   // Read data captured in the setup cycle
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         prdata <= 32'h00000000;
      else if (setup_phase && !pwrite)
         prdata <= next_rdata;
   end
endmodule
`default_nettype wire

// ### rtl/led_fault_pkg.sv
// Constants and types shared by the LED fault detection and removal logic
`default_nettype none
package led_fault_pkg;
   // Matrix geometry
   localparam int CHANNELS = 48;
   localparam int GROUP_SIZE = 16;
   localparam int LINES = 16;
   localparam int LINE_W = 4;
   localparam int REMOVAL_SLOTS = 3;
   localparam int THRESH_W = 4;
   // Register byte offsets
   localparam logic [7:0] CTRL_OFFSET = 8'h00;
   localparam logic [7:0] THRESH_OFFSET = 8'h04;
   localparam logic [7:0] STATUS_OFFSET = 8'h08;
   localparam logic [7:0] OPEN_LINE_OFFSET = 8'h0c;
   localparam logic [7:0] SHORT_LINE_OFFSET = 8'h10;
   localparam logic [7:0] OPEN_DATA_LO_OFFSET = 8'h14;
   localparam logic [7:0] OPEN_DATA_HI_OFFSET = 8'h18;
   localparam logic [7:0] SHORT_DATA_LO_OFFSET = 8'h1c;
   localparam logic [7:0] SHORT_DATA_HI_OFFSET = 8'h20;
   // Control register fields
   localparam int OPEN_REMOVAL_BIT = 0;
   localparam int READBACK_BIT = 1;
   // Threshold register field positions
   localparam int OPEN_RED_POS = 0;
   localparam int OPEN_GREEN_POS = 4;
   localparam int OPEN_BLUE_POS = 8;
   localparam int SHORT_RED_POS = 12;
   localparam int SHORT_GREEN_POS = 16;
   localparam int SHORT_BLUE_POS = 20;
   localparam int CLAMP_POS = 24;
   // Status register fields
   localparam int THERMAL_BIT = 0;
   localparam int REF_SHORT_BIT = 1;
   localparam int REMOVAL_COUNT_POS = 4;
   // Reset values
   localparam logic [1:0] CTRL_RESET = 2'h0;
   localparam logic [27:0] THRESH_RESET = 28'h0000000;
   // Analog settings sent to the comparators and line clamp
   typedef struct packed {
      logic [THRESH_W-1:0] short_removal_clamp;
      logic [THRESH_W-1:0] short_threshold_blue;
      logic [THRESH_W-1:0] short_threshold_green;
      logic [THRESH_W-1:0] short_threshold_red;
      logic [THRESH_W-1:0] open_threshold_blue;
      logic [THRESH_W-1:0] open_threshold_green;
      logic [THRESH_W-1:0] open_threshold_red;
   } analog_settings_t;
   // Scan position delivered by the display sequencer
   typedef struct packed {
      logic segment_end;
      logic [LINE_W-1:0] line;
      logic [CHANNELS-1:0] channel_on;
   } scan_t;
   // Colour group of a channel: 0 red, 1 green, 2 blue
   function automatic logic [1:0] color_group(input int ch);
      return 2'(ch / GROUP_SIZE);
   endfunction
endpackage
`default_nettype wire

// ### rtl/fault_capture.sv
// Per-channel fault sampler with segment latch and line warning record
`default_nettype none
module fault_capture
   import led_fault_pkg::*;
#(
   parameter int N = 48,
   parameter int NL = 16,
   parameter int LW = 4
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [N-1:0] cmp,
   input wire scan_t scan,
   input wire logic [NL-1:0] line_clear,
   output logic [N-1:0] seg_flags,
   output logic [N-1:0] data,
   output logic [NL-1:0] line_warning
);
   logic [N-1:0] acc;
   logic [N-1:0] hits;

   // Comparator output only counts while the channel is driven
   assign hits = cmp & scan.channel_on;
   assign seg_flags = acc | hits;

   // Accumulate within a segment, restart at its end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         acc <= '0;
      else if (scan.segment_end)
         acc <= '0;
      else
         acc <= seg_flags;
   end

   // Latch the channel flags at segment end
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         data <= '0;
      else if (scan.segment_end)
         data <= seg_flags;
   end

   // Sticky line record; a new fault beats a software clear
   always_ff @(posedge pclk or negedge presetn)
   begin
      if (!presetn)
         line_warning <= '0;
      else
      begin
         for (int l = 0; l < NL; l++)
         begin
            if (|hits && scan.line == LW'(l))
               line_warning[l] <= 1'b1;
            else if (line_clear[l])
               line_warning[l] <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ### sim/led_matrix_model.sv
// Behavioural LED matrix giving the channel comparator levels
`default_nettype none
module led_matrix_model
   import led_fault_pkg::*;
(
   input wire scan_t scan,
   input wire logic [CHANNELS-1:0] drive,
   input wire logic [LINE_W-1:0] fault_line,
   input wire logic [CHANNELS-1:0] open_map,
   input wire logic [CHANNELS-1:0] short_map,
   input wire logic leak,
   output logic [CHANNELS-1:0] open_cmp,
   output logic [CHANNELS-1:0] short_cmp
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [CHANNELS-1:0] hit;
   // Faulty LEDs sit on one line; leak flags undriven channels as well
   always_comb
   begin
      hit = '0;
      if (scan.line == fault_line)
         hit = drive | {CHANNELS{leak}};
      open_cmp = open_map & hit;
      short_cmp = short_map & hit;
   end
endmodule
`default_nettype wire

// ### sim/led_fault_detect_removal_properties.sv
// Concurrent checks on the ports of the LED fault block
`default_nettype none
module led_fault_props
   import led_fault_pkg::*;
#(
   parameter int N = CHANNELS,
   parameter int NL = LINES,
   parameter int SLOTS = REMOVAL_SLOTS
)
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic over_temp_trip,
   input wire logic over_temp_clear,
   input wire logic ref_short_trip,
   input wire logic ref_short_clear,
   input wire logic [N-1:0] open_cmp,
   input wire logic [N-1:0] short_cmp,
   input wire scan_t scan,
   input wire logic [N-1:0] channel_output,
   input wire analog_settings_t settings,
   input wire logic [N-1:0] open_channel_threshold_sel,
   input wire logic outputs_disabled
);
   timeunit 1ns;
   timeprecision 1ps;
   logic thr_wr;
   // Completed write to the threshold register
   assign thr_wr = psel && penable && pready && pwrite
      && paddr == THRESH_OFFSET;
   default clocking cb @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   a_heat_shuts_off:
      assert property (over_temp_trip [*3] |=> outputs_disabled)
      else $error("thermal trip did not disable outputs");
   a_ref_shuts_off:
      assert property (ref_short_trip [*3] |=> outputs_disabled)
      else $error("reference short did not disable outputs");
   a_dark_outputs:
      assert property (outputs_disabled |=> channel_output == '0)
      else $error("channel driven while disabled");
   a_hold_off:
      assert property ((!over_temp_clear && !ref_short_clear) [*3]
         ##0 outputs_disabled |=> outputs_disabled)
      else $error("outputs resumed without a clear");
   a_resume_on:
      assert property ((over_temp_clear && ref_short_clear
         && !over_temp_trip && !ref_short_trip) [*3] |=> !outputs_disabled)
      else $error("outputs did not resume");
   a_only_driven:
      assert property (1'b1 |=> (channel_output & ~$past(scan.channel_on))
         == '0)
      else $error("channel on outside its scan slot");
   a_thresh_load:
      assert property (thr_wr |=> settings == $past(pwdata[27:0]))
      else $error("threshold settings not loaded");
   a_clamp_stable:
      assert property (!thr_wr |=> $stable(settings))
      else $error("settings changed without a write");
endmodule
bind led_fault_detect_removal led_fault_props
   #(.N(N), .NL(NL), .SLOTS(SLOTS)) u_props (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .over_temp_trip(over_temp_trip),
   .over_temp_clear(over_temp_clear), .ref_short_trip(ref_short_trip),
   .ref_short_clear(ref_short_clear), .open_cmp(open_cmp),
   .short_cmp(short_cmp), .scan(scan), .channel_output(channel_output),
   .settings(settings),
   .open_channel_threshold_sel(open_channel_threshold_sel),
   .outputs_disabled(outputs_disabled)
);
`default_nettype wire

// ### sim/test_led_fault_detect_removal.sv
// Self-checking bench for the LED fault detection and removal block
`default_nettype none
module test_led_fault_detect_removal
   import led_fault_pkg::*;
   ;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [47:0] ALL = 48'hffff_ffff_ffff;
   localparam logic [47:0] ON = 48'h0fff_ffff_ffff;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [7:0] paddr = 8'h0;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, outputs_disabled;
   logic [1:0] trip = 2'h0, clr = 2'h0;
   logic [47:0] open_cmp, short_cmp, channel_output, sel;
   logic [47:0] fmap [2] = '{48'h0, 48'h0};
   logic [3:0] fault_line = 4'h0;
   logic leak = 1'b0;
   scan_t scan = '0;
   analog_settings_t settings;
   int bad_count = 0;
   int compares = 0;
   // Clock
   always #4 pclk = ~pclk;
   led_fault_detect_removal u_dut (
      .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .over_temp_trip(trip[0]),
      .over_temp_clear(clr[0]), .ref_short_trip(trip[1]),
      .ref_short_clear(clr[1]), .open_cmp(open_cmp), .short_cmp(short_cmp),
      .scan(scan), .channel_output(channel_output), .settings(settings),
      .open_channel_threshold_sel(sel), .outputs_disabled(outputs_disabled)
   );
   led_matrix_model u_matrix (
      .scan(scan), .drive(channel_output), .fault_line(fault_line),
      .open_map(fmap[0]), .short_map(fmap[1]), .leak(leak),
      .open_cmp(open_cmp), .short_cmp(short_cmp)
   );
   task automatic chk(input string what, input logic [63:0] x,
         input logic [63:0] got);
      compares++;
      if (got !== x)
      begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, x, got);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a,
         input logic [31:0] d, output logic [31:0] r, output logic e);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Wait for pready; only the watchdog ends a wait that never sees it
      while (pready !== 1'b1)
         @(posedge pclk);
      r = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] r;
      logic e;
      apb(1'b1, a, d, r, e);
   endtask
   task automatic rd(input logic [7:0] a, input logic [31:0] x);
      logic [31:0] r;
      logic e;
      apb(1'b0, a, 32'h0, r, e);
      chk($sformatf("reg %h", a), x, r);
      chk("pslverr", 1'b0, e);
   endtask
   task automatic scan_line(input logic [3:0] l, input logic [47:0] on,
         input logic [47:0] x);
      scan <= '{1'b0, l, 48'h0};
      repeat (3) @(posedge pclk);
      scan.channel_on <= on;
      repeat (5) @(posedge pclk);
      chk("channel_output", x, channel_output);
      scan.segment_end <= 1'b1;
      @(posedge pclk);
      scan.segment_end <= 1'b0;
      scan.channel_on <= 48'h0;
      @(posedge pclk);
   endtask
   task automatic t_regs;
      logic [31:0] r;
      logic e;
      rd(CTRL_OFFSET, 32'h0);
      rd(THRESH_OFFSET, 32'h0);
      rd(STATUS_OFFSET, 32'h0);
      apb(1'b0, 8'h40, 32'h0, r, e);
      chk("unmapped pslverr", 1'b1, e);
      chk("unmapped prdata", 32'h0, r);
      wr(THRESH_OFFSET, 32'h0a98_7654);
      rd(THRESH_OFFSET, 32'h0a98_7654);
      chk("open thresholds", 12'h654, settings[11:0]);
      chk("short thresholds", 12'h987, settings[23:12]);
      chk("clamp", 4'ha, settings.short_removal_clamp);
      chk("group select", 48'h0000_ffff_0000, sel);
   endtask
   task automatic t_protect(input int k);
      trip[k] <= 1'b1;
      repeat (5) @(posedge pclk);
      chk("disabled", 1'b1, outputs_disabled);
      scan_line(4'h0, ALL, 48'h0);
      rd(STATUS_OFFSET, 32'h1 << k);
      trip[k] <= 1'b0;
      repeat (5) @(posedge pclk);
      chk("disabled", 1'b1, outputs_disabled);
      clr <= 2'b11;
      repeat (5) @(posedge pclk);
      chk("disabled", 1'b0, outputs_disabled);
      clr <= 2'b00;
      scan_line(4'h0, ALL, ALL);
   endtask
   task automatic t_detect(input int k);
      logic [7:0] a;
      logic [7:0] w;
      a = OPEN_DATA_LO_OFFSET + 8'(8 * k);
      w = OPEN_LINE_OFFSET + 8'(4 * k);
      wr(CTRL_OFFSET, 32'h0);
      fault_line <= 4'h5;
      leak <= 1'b1;
      fmap[k] <= 48'h8001_0000_8001;
      scan_line(4'h5, ON, ON);
      leak <= 1'b0;
      fmap[k] <= 48'h0;
      rd(w, 32'h20);
      rd(SHORT_LINE_OFFSET - 8'(4 * k), 32'h0);
      rd(a, 32'h0);
      wr(CTRL_OFFSET, 32'h2);
      repeat (8) @(posedge pclk);
      rd(a, 32'h0000_8001);
      rd(a + 8'h4, 32'h0000_0001);
      wr(w, 32'h20);
      rd(w, 32'h0);
   endtask
   task automatic t_removal;
      wr(CTRL_OFFSET, 32'h1);
      for (int i = 1; i < 5; i++)
      begin
         fault_line <= 4'(i);
         fmap[0] <= 48'h1 << i;
         scan_line(4'(i), ALL, ALL);
      end
      fmap[0] <= 48'h0;
      rd(STATUS_OFFSET, 32'h30);
      for (int i = 1; i < 5; i++)
         scan_line(4'(i), ALL, i < 4 ? ~(48'h1 << i) : ALL);
      scan_line(4'h0, ALL, ALL);
      wr(CTRL_OFFSET, 32'h0);
      rd(STATUS_OFFSET, 32'h0);
      scan_line(4'h1, ALL, ALL);
   endtask
   task automatic end_of_test;
      $display("compares %0d bad_count %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // Main sequence after a 20 cycle reset
   initial
   begin
      repeat (20) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      t_regs();
      t_protect(0);
      t_protect(1);
      t_detect(0);
      t_detect(1);
      t_removal();
      end_of_test();
   end
   // Watchdog against a hung handshake
   initial
   begin
      repeat (5000) @(posedge pclk);
      bad_count++;
      end_of_test();
   end
endmodule
`default_nettype wire
